// >>> common/t8wg_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the timer.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register a word.
// Notes: Definitions only.
`ifndef T8WG_DEFINES_SVH
`define T8WG_DEFINES_SVH

`define T8WG_ADDR_W 5
`define T8WG_OFF_CONTROL 5'h00
`define T8WG_OFF_COUNT 5'h04
`define T8WG_OFF_COMPARE 5'h08
`define T8WG_OFF_STATUS 5'h0c
`define T8WG_OFF_CONFIG 5'h10

`define T8WG_BIT_FORCE 7
`define T8WG_BIT_MODE_LO 6
`define T8WG_BIT_COM_HI 5
`define T8WG_BIT_COM_LO 4
`define T8WG_BIT_MODE_HI 3

`define T8WG_ST_OVERFLOW 0
`define T8WG_ST_MATCH 1
`define T8WG_ST_COUNT 2

`define T8WG_CFG_ASYNC 0
`define T8WG_CFG_DIR 1
`define T8WG_CFG_LEVEL 2

`define T8WG_CTRL_RST 7'h00
`define T8WG_CFG_RST 3'h0
`define T8WG_BYTE_RST 8'h00
`define T8WG_CNT_MAX 8'hff
`define T8WG_CNT_BOTTOM 8'h00
`define T8WG_CNT_ONE 8'h01

`define T8WG_COM_OFF 2'h0
`define T8WG_COM_TOGGLE 2'h1
`define T8WG_COM_CLEAR 2'h2
`define T8WG_COM_SET 2'h3

`define T8WG_RESP_OKAY 2'h0
`define T8WG_RESP_SLVERR 2'h2

`endif

// >>> common/t8wg_pkg.sv
// Purpose: Types shared by the timer files.
// Assumes: Nothing beyond the defines header.
// Notes: Mode codes follow the two mode bits, upper bit first.
package t8wg_pkg;

    typedef enum logic [1:0]
    {
        T8WG_NORMAL = 2'h0,
        T8WG_PHASE_PWM = 2'h1,
        T8WG_CLEAR_MATCH = 2'h2,
        T8WG_FAST_PWM = 2'h3
    } t8wg_mode_t;

endpackage

// >>> core/t8wg_counter.sv
// Purpose: Eight-bit counting sequence of the timer in all four modes.
// Assumes: Tick is a one-cycle enable; load wins over a tick.
// Notes: Counting_up tells the direction of the coming step in phase mode.
`include "t8wg_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module t8wg_counter #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire t8wg_pkg::t8wg_mode_t mode,
    input wire logic clear_hit,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] count,
    output logic counting_up
);

    logic dir_up;
    logic [WIDTH-1:0] next_count;
    logic next_dir_up;
    wire at_max = (count == `T8WG_CNT_MAX);
    wire at_bottom = (count == `T8WG_CNT_BOTTOM);
    wire is_phase = (mode == t8wg_pkg::T8WG_PHASE_PWM);
    wire is_clear = (mode == t8wg_pkg::T8WG_CLEAR_MATCH);

    // Phase mode turns at both ends, so each end is held one tick.
    assign counting_up = dir_up ? !at_max : at_bottom;
    // Normal and fast modes wrap after 256 ticks, dual slope repeats every 510.
    assign next_dir_up = is_phase ? counting_up : 1'b1;
    assign next_count = (is_clear && clear_hit) ? `T8WG_CNT_BOTTOM :
                        (is_phase && !counting_up) ? count - `T8WG_CNT_ONE :
                        count + `T8WG_CNT_ONE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= `T8WG_CNT_BOTTOM;
            dir_up <= 1'b1;
        end
        else if (load)
        begin
            count <= load_value;
        end
        else if (tick)
        begin
            count <= next_count;
            dir_up <= next_dir_up;
        end
    end

endmodule
`default_nettype wire

// >>> core/t8wg_timer.sv
// Purpose: Eight-bit timer with waveform output behind an AXI4-Lite slave.
// Assumes: Ticks and pin inputs are synchronous to aclk.
// Notes: Write responses come two cycles after both halves are taken.
//
// Contract
// - Overflow flag set at maximum, non-phase modes.
// - Fast mode: codes 2/3 clear/set at match.
// - Fast mode code 1 toggles on match.
// - Fast mode codes 2/3 bottom spike, maximum constant level.
// - Fast mode codes 2/3 compare at top ignored, top action done.
// - Phase mode counts up, down, holds max once.
// - Phase mode period is 510 ticks, eight bits.
// - Phase mode sets overflow flag at bottom.
// - Phase mode codes 2/3 act by direction.
// - Phase mode extreme compare values give constant levels.
// - Fast mode period is 256 ticks.
// - Timer advances on selected tick enable.
// - Force strobe applies output action, non-PWM only.
// - Force strobe sets no flag, clears no counter.
// - Force strobe bit always reads zero.
// - Mode field at bits 6 and 3.
// - Compare value double-buffered in PWM modes only.
// - Nonzero output mode overrides the port pin, except code 1 in phase mode.
// - Non-PWM output modes: off, toggle, clear, set.
// - Clear-on-match mode resets counter at compare.
// - Counter write blocks the next tick's match.
// - Output mode change acts at next match.
`include "t8wg_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module t8wg_timer #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`T8WG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`T8WG_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_clock_enable,
    input wire logic osc_tick,
    output logic compare_output_pin,
    output logic compare_output_oe
);

    function automatic logic is_pwm(input t8wg_pkg::t8wg_mode_t m);
        is_pwm = (m == t8wg_pkg::T8WG_PHASE_PWM) ||
                 (m == t8wg_pkg::T8WG_FAST_PWM);
    endfunction

    function automatic logic apply_action(input logic [1:0] c,
                                          input logic cur);
        case (c)
            `T8WG_COM_TOGGLE: apply_action = !cur;
            `T8WG_COM_CLEAR: apply_action = 1'b0;
            `T8WG_COM_SET: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction

    function automatic logic mapped(input logic [`T8WG_ADDR_W-1:0] a);
        mapped = (a == `T8WG_OFF_CONTROL) || (a == `T8WG_OFF_COUNT) ||
                 (a == `T8WG_OFF_COMPARE) || (a == `T8WG_OFF_STATUS) ||
                 (a == `T8WG_OFF_CONFIG);
    endfunction

    // Register state.
    logic [6:0] timer_waveform_control;
    logic [WIDTH-1:0] compare_buffer;
    logic [WIDTH-1:0] compare_value;
    logic [2:0] config_bits;
    logic [1:0] flags;
    logic compare_output;
    logic match_block;

    // Bus state.
    logic aw_held;
    logic w_held;
    logic [`T8WG_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Counter.
    logic [WIDTH-1:0] count_value;
    logic counting_up;

    // Write channel sequencing; one write in flight at a time.
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire b_hs = s_axi_bvalid && s_axi_bready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire next_aw_held = aw_hs ? 1'b1 : (wr_go ? 1'b0 : aw_held);
    wire next_w_held = w_hs ? 1'b1 : (wr_go ? 1'b0 : w_held);
    wire next_bvalid = wr_go ? 1'b1 : (b_hs ? 1'b0 : s_axi_bvalid);
    wire wr_byte = wr_go && w_strb[0];
    wire [7:0] wr_data = w_data[7:0];

    // Read channel sequencing.
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire r_hs = s_axi_rvalid && s_axi_rready;
    wire next_rvalid = ar_hs ? 1'b1 : (r_hs ? 1'b0 : s_axi_rvalid);

    // Register decode.
    wire ctrl_wr = wr_byte && (aw_addr == `T8WG_OFF_CONTROL);
    wire cnt_wr = wr_byte && (aw_addr == `T8WG_OFF_COUNT);
    wire cmp_wr = wr_byte && (aw_addr == `T8WG_OFF_COMPARE);
    wire stat_wr = wr_byte && (aw_addr == `T8WG_OFF_STATUS);
    wire cfg_wr = wr_byte && (aw_addr == `T8WG_OFF_CONFIG);

    // Mode and output-mode fields.
    wire t8wg_pkg::t8wg_mode_t mode = t8wg_pkg::t8wg_mode_t'(
        {timer_waveform_control[`T8WG_BIT_MODE_HI],
         timer_waveform_control[`T8WG_BIT_MODE_LO]});
    wire [1:0] output_mode_field =
        timer_waveform_control[`T8WG_BIT_COM_HI:`T8WG_BIT_COM_LO];
    wire output_mode_upper_bit = output_mode_field[1];
    wire pwm_mode = is_pwm(mode);
    wire phase_mode = (mode == t8wg_pkg::T8WG_PHASE_PWM);
    wire fast_mode = (mode == t8wg_pkg::T8WG_FAST_PWM);

    // Fields as they are being written, for the force strobe.
    wire t8wg_pkg::t8wg_mode_t wr_mode = t8wg_pkg::t8wg_mode_t'(
        {wr_data[`T8WG_BIT_MODE_HI], wr_data[`T8WG_BIT_MODE_LO]});
    wire [1:0] wr_com = wr_data[`T8WG_BIT_COM_HI:`T8WG_BIT_COM_LO];
    // A strobe while a PWM mode is written is dropped, so software that
    // leaves the bit set there does no harm.
    wire force_evt = ctrl_wr && wr_data[`T8WG_BIT_FORCE] && !is_pwm(wr_mode);

    // Tick selection.
    wire async_sel = config_bits[`T8WG_CFG_ASYNC];
    wire tick = async_sel ? osc_tick : timer_clock_enable;

    // Compare and top events; a counter write blocks the next match.
    wire at_max = (count_value == `T8WG_CNT_MAX);
    wire cmp_equal = (count_value == compare_value);
    wire match = tick && cmp_equal && !match_block && !cnt_wr;
    wire top_evt = tick && at_max && !cnt_wr;
    wire cmp_at_top = (compare_value == `T8WG_CNT_MAX);

    // Overflow: at maximum outside phase mode, at bottom inside it.
    wire ovf_max = !phase_mode && top_evt;
    wire ovf_bottom = phase_mode && tick && !cnt_wr && !counting_up &&
                      (count_value == `T8WG_CNT_ONE);
    wire ovf_set = ovf_max || ovf_bottom;

    // Output actions; the live field is read at the event itself.
    wire nonpwm_act = !pwm_mode && match;
    wire fast_ignore = cmp_at_top && output_mode_upper_bit;
    wire fast_match = fast_mode && match && !fast_ignore;
    wire fast_top = fast_mode && top_evt && output_mode_upper_bit;
    // In fast mode codes 2/3 a bottom compare value gives a one-tick spike after
    // the wrap, a top value leaves only the top action, so the level stays fixed.
    wire phase_act = phase_mode && match && output_mode_upper_bit;
    // At a top compare value only the down action can happen, which is the
    // top action; at bottom only the up action.
    wire phase_level = counting_up ? output_mode_field[0]
                                   : !output_mode_field[0];
    wire next_compare_output =
        force_evt ? apply_action(wr_com, compare_output) :
        phase_act ? phase_level :
        fast_top ? !output_mode_field[0] :
        (fast_match || nonpwm_act) ?
            apply_action(output_mode_field, compare_output) :
        compare_output;

    // Pin override; reserved code in phase mode stays on the port.
    wire pin_override = (output_mode_field != `T8WG_COM_OFF) &&
        !(phase_mode && output_mode_field == `T8WG_COM_TOGGLE);
    wire next_pin = pin_override ? compare_output
                                 : config_bits[`T8WG_CFG_LEVEL];

    // Read data mux; the strobe bit reads zero.
    wire [7:0] rd_byte =
        (s_axi_araddr == `T8WG_OFF_CONTROL) ? {1'b0, timer_waveform_control} :
        (s_axi_araddr == `T8WG_OFF_COUNT) ? count_value :
        (s_axi_araddr == `T8WG_OFF_COMPARE) ? compare_buffer :
        (s_axi_araddr == `T8WG_OFF_STATUS) ? {6'h00, flags} :
        (s_axi_araddr == `T8WG_OFF_CONFIG) ? {5'h00, config_bits} :
        `T8WG_BYTE_RST;

    t8wg_counter #(
        .WIDTH(WIDTH)
    ) u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .mode(mode),
        .clear_hit(match),
        .load(cnt_wr),
        .load_value(wr_data),
        .count(count_value),
        .counting_up(counting_up)
    );

    // Bus handshakes.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr <= `T8WG_OFF_CONTROL;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bresp <= `T8WG_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
                aw_addr <= s_axi_awaddr;
            if (w_hs)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
                s_axi_bresp <= mapped(aw_addr) ? `T8WG_RESP_OKAY
                                               : `T8WG_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `T8WG_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs)
            begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= mapped(s_axi_araddr) ? `T8WG_RESP_OKAY
                                                    : `T8WG_RESP_SLVERR;
            end
        end
    end

    // Control and configuration registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_waveform_control <= `T8WG_CTRL_RST;
            config_bits <= `T8WG_CFG_RST;
        end
        else
        begin
            if (ctrl_wr)
                timer_waveform_control <= wr_data[6:0];
            if (cfg_wr)
                config_bits <= wr_data[2:0];
        end
    end

    // Compare value: immediate outside PWM, loaded at top inside it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_buffer <= `T8WG_BYTE_RST;
            compare_value <= `T8WG_BYTE_RST;
        end
        else
        begin
            if (cmp_wr)
                compare_buffer <= wr_data;
            if (!pwm_mode)
                compare_value <= cmp_wr ? wr_data : compare_buffer;
            else if (top_evt)
                compare_value <= compare_buffer;
        end
    end

    // Match block lasts until the tick after a counter write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            match_block <= 1'b0;
        else if (cnt_wr)
            match_block <= 1'b1;
        else if (tick)
            match_block <= 1'b0;
    end

    // Sticky flags, write one to clear; a set in the clearing cycle wins.
    // The strobe never reaches these sets.
    wire [1:0] flag_set = {match, ovf_set};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_flag
            wire clr = stat_wr && wr_data[gi];
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    flags[gi] <= 1'b0;
                else
                    flags[gi] <= flag_set[gi] || (flags[gi] && !clr);
            end
        end
    endgenerate

    // Waveform register and the pin.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_output <= 1'b0;
            compare_output_pin <= 1'b0;
            compare_output_oe <= 1'b0;
        end
        else
        begin
            compare_output <= next_compare_output;
            compare_output_pin <= next_pin;
            compare_output_oe <= config_bits[`T8WG_CFG_DIR];
        end
    end

endmodule
`default_nettype wire

// >>> dv/t8wg_pin_load.sv
// Purpose: Load on the compare output pin, with a pull-down resistor.
// Assumes: The pin level is sampled on aclk, as the timer drives it.
// Notes: Period is the spacing of the last two rising edges in cycles.
`timescale 1ns/10ps
`default_nettype none
module t8wg_pin_load (
    input wire logic aclk,
    input wire logic pin,
    input wire logic oe,
    input wire logic clr,
    output logic line,
    output logic [15:0] edges,
    output logic [15:0] period
);
    logic [15:0] now = 16'h0;
    logic [15:0] last = 16'h0;
    logic prev = 1'b0;
    // A released pin falls to the pull-down, never keeps its last level.
    assign line = oe ? pin : 1'b0;
    always @(posedge aclk)
    begin
        now <= now + 16'h1;
        prev <= line;
        if (clr)
            edges <= 16'h0;
        else if (line != prev)
            edges <= edges + 16'h1;
        if (line && !prev)
        begin
            period <= now - last;
            last <= now;
        end
    end
endmodule
`default_nettype wire

// >>> dv/t8wg_timer_monitor.sv
// Purpose: Concurrent checks on the timer's bus and pin ports.
// Assumes: Bound to every instance of the timer top module.
// Notes: Only ports are seen, so register contents are not judged here.
`include "t8wg_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module t8wg_timer_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`T8WG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_clock_enable,
    input wire logic osc_tick,
    input wire logic compare_output_pin
);
    logic [`T8WG_ADDR_W-1:0] rd_addr;
    logic [1:0] quiet;
    logic rd_hs;
    assign rd_hs = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        rd_hs;
    endsequence
    always_ff @(posedge aclk)
    begin
        if (rd_hs)
            rd_addr <= s_axi_araddr;
    end
    // The pin may move only a few cycles after a tick or a write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || s_axi_awvalid || s_axi_wvalid || timer_clock_enable
            || osc_tick)
            quiet <= 2'h0;
        else if (quiet != 2'h3)
            quiet <= quiet + 2'h1;
    end
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    write_refuse_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    strobe_read_a: assert property (
        s_axi_rvalid && rd_addr == `T8WG_OFF_CONTROL |-> !s_axi_rdata[7])
        else $error("strobe bit read as one");
    unmapped_read_a: assert property (s_axi_rvalid && rd_addr[4:2] > 3'h4
        |-> s_axi_rresp == `T8WG_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    pin_quiet_a: assert property (
        quiet == 2'h3 |-> $stable(compare_output_pin))
        else $error("pin moved without tick");
endmodule
bind t8wg_timer t8wg_timer_monitor u_monitor (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_clock_enable(timer_clock_enable),
    .osc_tick(osc_tick), .compare_output_pin(compare_output_pin));
`default_nettype wire

// >>> dv/test_t8wg_timer.sv
// Purpose: Self-checking bench of the waveform timer.
// Assumes: Ticks stay low during bus cycles, so counts are exact.
// Notes: Long runs hold the tick high.
`include "t8wg_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module test_t8wg_timer;
    localparam int LIMIT = 32'h4e20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h0;
    logic [4:0] araddr = 5'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic te = 1'b0;
    logic osc = 1'b0;
    logic clr = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, pin, oe, line;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [15:0] edges, period;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    t8wg_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_clock_enable(te), .osc_tick(osc),
        .compare_output_pin(pin), .compare_output_oe(oe));
    t8wg_pin_load u_load (.aclk(aclk), .pin(pin), .oe(oe), .clr(clr),
        .line(line), .edges(edges), .period(period));
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            aw = aw && !awready;
            w = w && !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdt(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        rdt(a);
        cmp(rd, exp);
    endtask
    task automatic tk(input int n, input logic o);
        repeat (n)
        begin
            @(posedge aclk);
            te <= !o;
            osc <= o;
            @(posedge aclk);
            te <= 1'b0;
            osc <= 1'b0;
        end
    endtask
    task automatic run(input int n);
        @(posedge aclk);
        te <= 1'b1;
        repeat (n) @(posedge aclk);
        te <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m,
        input logic [1:0] c, input logic f);
        return {24'h0, f, m[0], c, m[1], 3'h0};
    endfunction
    task automatic t_regs();
        rchk(`T8WG_OFF_CONTROL, 32'h0);
        wr(`T8WG_OFF_CONTROL, ctl(2'h3, 2'h2, 1'b0));
        rchk(`T8WG_OFF_CONTROL, 32'h68);
        wr(`T8WG_OFF_CONTROL, 32'h80);
        rchk(`T8WG_OFF_CONTROL, 32'h0);
        wr(5'h14, 32'h1);
        cmp({30'h0, rs}, {30'h0, `T8WG_RESP_SLVERR});
        rchk(5'h14, 32'h0);
        cmp({30'h0, rs}, {30'h0, `T8WG_RESP_SLVERR});
    endtask
    task automatic t_force();
        wr(`T8WG_OFF_CONFIG, 32'h6);
        wr(`T8WG_OFF_CONTROL, 32'h0);
        tk(1, 1'b1);
        cmpb(line, 1'b1);
        wr(`T8WG_OFF_CONFIG, 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            wr(`T8WG_OFF_CONTROL, ctl(2'h0, 2'(3 - i), 1'b1));
            repeat (3) @(posedge aclk);
            cmpb(line, i != 1);
        end
        rchk(`T8WG_OFF_STATUS, 32'h0);
        wr(`T8WG_OFF_COUNT, 32'h5);
        wr(`T8WG_OFF_CONTROL, ctl(2'h2, 2'h2, 1'b1));
        rchk(`T8WG_OFF_COUNT, 32'h5);
        cmpb(line, 1'b0);
        // This write sets the strobe in a PWM mode on purpose.
        wr(`T8WG_OFF_CONTROL, ctl(2'h3, 2'h3, 1'b1));
        repeat (3) @(posedge aclk);
        cmpb(line, 1'b0);
    endtask
    task automatic t_flags();
        wr(`T8WG_OFF_CONTROL, 32'h0);
        wr(`T8WG_OFF_COMPARE, 32'h80);
        wr(`T8WG_OFF_COUNT, 32'hfe);
        tk(1, 1'b0);
        rchk(`T8WG_OFF_STATUS, 32'h0);
        tk(1, 1'b0);
        rchk(`T8WG_OFF_STATUS, 32'h1);
        wr(`T8WG_OFF_CONTROL, ctl(2'h1, 2'h0, 1'b0));
        wr(`T8WG_OFF_STATUS, 32'h3);
        wr(`T8WG_OFF_COUNT, 32'hfe);
        tk(2, 1'b0);
        rchk(`T8WG_OFF_STATUS, 32'h0);
        rchk(`T8WG_OFF_COUNT, 32'hfe);
        wr(`T8WG_OFF_COUNT, 32'h2);
        tk(2, 1'b0);
        rchk(`T8WG_OFF_STATUS, 32'h1);
        tk(1, 1'b0);
        rchk(`T8WG_OFF_COUNT, 32'h1);
        wr(`T8WG_OFF_CONTROL, ctl(2'h2, 2'h0, 1'b0));
        wr(`T8WG_OFF_STATUS, 32'h3);
        wr(`T8WG_OFF_COMPARE, 32'h3);
        wr(`T8WG_OFF_COUNT, 32'h0);
        tk(3, 1'b0);
        rchk(`T8WG_OFF_COUNT, 32'h3);
        tk(1, 1'b0);
        rchk(`T8WG_OFF_COUNT, 32'h0);
        rchk(`T8WG_OFF_STATUS, 32'h2);
        wr(`T8WG_OFF_COUNT, 32'h3);
        tk(1, 1'b0);
        rchk(`T8WG_OFF_COUNT, 32'h4);
    endtask
    task automatic t_async();
        wr(`T8WG_OFF_CONTROL, 32'h0);
        wr(`T8WG_OFF_COUNT, 32'h0);
        wr(`T8WG_OFF_CONFIG, 32'h3);
        tk(3, 1'b0);
        rchk(`T8WG_OFF_COUNT, 32'h0);
        tk(2, 1'b1);
        rchk(`T8WG_OFF_COUNT, 32'h2);
        wr(`T8WG_OFF_CONFIG, 32'h2);
    endtask
    task automatic t_pwm();
        logic [1:0] m [5] = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h3};
        logic [1:0] c [5] = '{2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
        logic [7:0] v [5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hff};
        logic l [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        wr(`T8WG_OFF_CONTROL, ctl(2'h3, 2'h2, 1'b0));
        wr(`T8WG_OFF_COMPARE, 32'h80);
        run(800);
        cmp({16'h0, period}, 32'h100);
        wr(`T8WG_OFF_CONTROL, ctl(2'h3, 2'h1, 1'b0));
        run(1100);
        cmp({16'h0, period}, 32'h200);
        wr(`T8WG_OFF_CONTROL, ctl(2'h1, 2'h2, 1'b0));
        wr(`T8WG_OFF_COMPARE, 32'h40);
        run(1600);
        cmp({16'h0, period}, 32'h1fe);
        for (int i = 0; i < 5; i++)
        begin
            wr(`T8WG_OFF_CONTROL, ctl(m[i], c[i], 1'b0));
            wr(`T8WG_OFF_COMPARE, {24'h0, v[i]});
            run(1024);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            run(600);
            cmp({16'h0, edges}, 32'h0);
            cmpb(line, l[i]);
        end
        wr(`T8WG_OFF_CONFIG, 32'h6);
        wr(`T8WG_OFF_CONTROL, ctl(2'h1, 2'h1, 1'b0));
        repeat (3) @(posedge aclk);
        cmpb(line, 1'b1);
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        clr <= 1'b0;
        t_regs();
        t_force();
        t_flags();
        t_async();
        t_pwm();
        end_sim();
    end
endmodule
`default_nettype wire
